// ### logic/interrupt_vector_priority_defines.svh
`ifndef INTERRUPT_VECTOR_PRIORITY_DEFINES_SVH
`define INTERRUPT_VECTOR_PRIORITY_DEFINES_SVH
// Register indices on the plain register port
`define IVP_REG_FLAGS 8'h00
`define IVP_REG_MASK 8'h01
`define IVP_REG_ROUTE 8'h02
`define IVP_REG_SERVICE 8'h03
`define IVP_REG_EVENTS 8'h04
`define IVP_REG_EV_MASK 8'h05
// Widths and counts
`define IVP_NUM_SRC 14
`define IVP_NUM_ROUTE 4
`define IVP_NUM_EV 3
// Vector word locations and priorities
`define IVP_VEC_RESET 7'h00
`define IVP_VEC_NMI 7'h04
`define IVP_VEC_MASK_BASE 7'h40
`define IVP_PRI_RESET 5'h01
`define IVP_PRI_NMI 5'h02
`define IVP_PRI_MASK_BASE 5'h03
// Soft trap numbers with fixed meaning
`define IVP_TRAP_NMI 5'h10
`define IVP_TRAP_FLAG_HI 5'h0D
`define IVP_TRAP_SOFT_LO 5'h11
`define IVP_TRAP_SOFT_HI 5'h1E
`define IVP_TRAP_SOFT_BIAS 5'h0F
// Event status bit positions
`define IVP_EV_TAKEN 0
`define IVP_EV_LOST 1
`define IVP_EV_BAD_TRAP 2
`endif

// ### logic/interrupt_vector_priority_pkg.sv
package interrupt_vector_priority_pkg;
  // Which kind of source the core is being offered
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_RESET = 2'h1,
    SRC_NMI = 2'h3,
    SRC_MASKABLE = 2'h2
  } src_kind_e;
  // What the core sees on the vector port
  typedef struct packed {
    logic req;
    logic [4:0] level;
    logic [6:0] vector;
  } service_s;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;
endpackage : interrupt_vector_priority_pkg

// ### logic/interrupt_vector_priority.sv
`timescale 1ns/100ps
`include "interrupt_vector_priority_defines.svh"
module interrupt_vector_priority
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Reset and trap requests
  input wire logic reset_pin_n,
  input wire logic soft_reset_trap,
  input wire logic nmi_request,
  input wire logic soft_trap_valid,
  input wire logic [4:0] soft_trap_num,
  // Maskable request pulses
  input wire logic ext_request_0,
  input wire logic ext_request_1,
  input wire logic ext_request_2,
  input wire logic ext_request_3,
  input wire logic timer_event,
  input wire logic serial0_rx_event,
  input wire logic serial0_tx_event,
  input wire logic serial1_rx_event,
  input wire logic serial1_tx_event,
  input wire logic serial2_rx_event,
  input wire logic serial2_tx_event,
  input wire logic host_port_event,
  input wire logic dma_ch0_event,
  input wire logic dma_ch1_event,
  input wire logic dma_ch2_event,
  input wire logic dma_ch3_event,
  input wire logic dma_ch4_event,
  input wire logic dma_ch5_event,
  // Core vector port
  input wire logic cpu_ack,
  output interrupt_vector_priority_pkg::service_s cpu_service,
  output logic trap_valid,
  output logic [6:0] trap_vector,
  // Register port
  input wire interrupt_vector_priority_pkg::reg_req_s reg_req,
  output logic [15:0] rdata,
  // Interrupt to software
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // State
  // Sticky per-source flags and their enables, one bit per slot
  logic [13:0] pending_flags;
  logic [13:0] enable_mask;
  // Route bits pick DMA over the serial port for the shared slots
  logic [3:0] dma_route;
  // Block events and their enables, for the software interrupt
  logic [2:0] ctl_events;
  logic [2:0] ctl_ev_mask;
  // Reset and nonmaskable sit above the flag word, never masked
  logic reset_pend;
  logic nmi_pend;
  // What was offered last edge; an ack retires exactly this source
  interrupt_vector_priority_pkg::src_kind_e cur_kind;
  logic [3:0] cur_bit;

  ////////////////////////////////////////////////////////////////////
  // Register decode
  wire logic sel_flags = reg_req.addr == `IVP_REG_FLAGS;
  wire logic sel_mask = reg_req.addr == `IVP_REG_MASK;
  wire logic sel_route = reg_req.addr == `IVP_REG_ROUTE;
  wire logic sel_service = reg_req.addr == `IVP_REG_SERVICE;
  wire logic sel_events = reg_req.addr == `IVP_REG_EVENTS;
  wire logic sel_ev_mask = reg_req.addr == `IVP_REG_EV_MASK;
  // Strobes qualified by address; an unmapped write matches nothing
  wire logic wr_flags = reg_req.wr & sel_flags;
  wire logic wr_mask = reg_req.wr & sel_mask;
  wire logic wr_route = reg_req.wr & sel_route;
  wire logic wr_ev_mask = reg_req.wr & sel_ev_mask;
  wire logic rd_events = reg_req.rd & sel_events;

  ////////////////////////////////////////////////////////////////////
  // Source routing; the serial port owns shared slots by default
  // A source routed away has its pulses dropped, not queued
  wire logic [13:0] src_req = {
    dma_ch5_event,
    dma_ch4_event,
    dma_route[3] ? dma_ch3_event : serial1_tx_event,
    dma_route[2] ? dma_ch2_event : serial1_rx_event,
    host_port_event,
    ext_request_3,
    dma_route[1] ? dma_ch1_event : serial2_tx_event,
    dma_route[0] ? dma_ch0_event : serial2_rx_event,
    serial0_tx_event,
    serial0_rx_event,
    timer_event,
    ext_request_2,
    ext_request_1,
    ext_request_0
  };

  ////////////////////////////////////////////////////////////////////
  // Acknowledge decode against what the core was offered
  // An ack with nothing offered is ignored
  wire logic ack_live = cpu_ack & cpu_service.req;
  wire logic ack_reset =
    ack_live & (cur_kind == interrupt_vector_priority_pkg::SRC_RESET);
  wire logic ack_nmi =
    ack_live & (cur_kind == interrupt_vector_priority_pkg::SRC_NMI);
  wire logic ack_mask =
    ack_live & (cur_kind == interrupt_vector_priority_pkg::SRC_MASKABLE);

  ////////////////////////////////////////////////////////////////////
  // Soft trap decode; slots 6 and 7 are swapped in trap numbering
  // Traps below 14 only vector; they leave the flags alone
  wire logic trap_low = soft_trap_num <= `IVP_TRAP_FLAG_HI;
  wire logic trap_nmi = soft_trap_num == `IVP_TRAP_NMI;
  wire logic trap_soft = (soft_trap_num >= `IVP_TRAP_SOFT_LO) &
    (soft_trap_num <= `IVP_TRAP_SOFT_HI);
  // Numbers 14, 15 and 31 own no slot and raise an event instead
  wire logic trap_ok = soft_trap_valid & (trap_low | trap_nmi | trap_soft);
  wire logic trap_bad = soft_trap_valid & ~trap_ok;
  wire logic [3:0] trap_bit =
    (soft_trap_num == 5'h06) ? 4'h7 :
    (soft_trap_num == 5'h07) ? 4'h6 : soft_trap_num[3:0];
  wire logic [4:0] trap_soft_idx = soft_trap_num - `IVP_TRAP_SOFT_BIAS;
  wire logic [6:0] next_trap_vector =
    trap_nmi ? `IVP_VEC_NMI :
    trap_soft ? {trap_soft_idx, 2'h0} :
    `IVP_VEC_MASK_BASE + {1'h0, trap_bit, 2'h0};

  ////////////////////////////////////////////////////////////////////
  // Per-source flag: a new request wins over any clear in the same
  // cycle, so nothing is lost to a write-one-to-clear race
  logic [13:0] next_flags;
  logic [13:0] lost_req;
  genvar gi;
  generate
    for (gi = 0; gi < `IVP_NUM_SRC; gi = gi + 1)
    begin : g_flag
      wire logic clr = (wr_flags & reg_req.wdata[gi]) |
        (ack_mask & (cur_bit == 4'(gi)));
      assign next_flags[gi] =
        src_req[gi] | (pending_flags[gi] & ~clr);
      assign lost_req[gi] = src_req[gi] & pending_flags[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Reset and nonmaskable pending; the pin holds reset pending
  // Software reset is a one-cycle pulse held until acked; only the pin holds past an ack
  wire logic next_reset_pend = ~reset_pin_n | soft_reset_trap |
    (reset_pend & ~ack_reset);
  // Trap sixteen is the software face of the nonmaskable request
  wire logic next_nmi_pend = nmi_request |
    (soft_trap_valid & trap_nmi) | (nmi_pend & ~ack_nmi);

  ////////////////////////////////////////////////////////////////////
  // Lowest enabled bit is the smallest priority number
  // Scan runs down so the last hit kept is the lowest bit
  function automatic logic [3:0] lowest_bit(input logic [13:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int k = `IVP_NUM_SRC - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        idx = 4'(k);
      end
    end
    return idx;
  endfunction : lowest_bit

  // The pick sees next-state flags and mask, so a write or an ack
  // counts at the same edge and the offer never lags by a cycle
  wire logic [13:0] next_mask =
    wr_mask ? reg_req.wdata[13:0] : enable_mask;
  wire logic [13:0] next_live = next_flags & next_mask;
  wire logic live_any = |next_live;
  wire logic [3:0] live_bit = lowest_bit(next_live);

  ////////////////////////////////////////////////////////////////////
  // Selection: reset, then nonmaskable, then maskable by bit
  wire interrupt_vector_priority_pkg::src_kind_e next_kind =
    next_reset_pend ? interrupt_vector_priority_pkg::SRC_RESET :
    next_nmi_pend ? interrupt_vector_priority_pkg::SRC_NMI :
    live_any ? interrupt_vector_priority_pkg::SRC_MASKABLE :
    interrupt_vector_priority_pkg::SRC_NONE;
  interrupt_vector_priority_pkg::service_s next_service;
  always_comb
  begin
    next_service.req = next_kind != interrupt_vector_priority_pkg::SRC_NONE;
    // Reset and nonmaskable own fixed slots above the flag word
    case (next_kind)
      interrupt_vector_priority_pkg::SRC_RESET:
      begin
        next_service.level = `IVP_PRI_RESET;
        next_service.vector = `IVP_VEC_RESET;
      end
      interrupt_vector_priority_pkg::SRC_NMI:
      begin
        next_service.level = `IVP_PRI_NMI;
        next_service.vector = `IVP_VEC_NMI;
      end
      interrupt_vector_priority_pkg::SRC_MASKABLE:
      begin
        // Four words per slot; bit 13 tops out at 74, never 78-7F
        next_service.level = `IVP_PRI_MASK_BASE + {1'h0, live_bit};
        next_service.vector =
          `IVP_VEC_MASK_BASE + {1'h0, live_bit, 2'h0};
      end
      default:
      begin
        next_service.level = 5'h00;
        next_service.vector = 7'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Block events, sticky; set beats the read that clears them
  // Bit 1 catches a source that pulsed again before service
  wire logic [2:0] ev_set = {trap_bad, |lost_req, ack_live};
  wire logic [2:0] next_events =
    ev_set | (ctl_events & ~{3{rd_events}});
  wire logic [2:0] next_ev_mask =
    wr_ev_mask ? reg_req.wdata[2:0] : ctl_ev_mask;

  ////////////////////////////////////////////////////////////////////
  // Read data mux, valid only the cycle after the read strobe
  // Unmapped addresses read as zero
  wire logic [15:0] rd_mux =
    sel_flags ? {2'h0, pending_flags} :
    sel_mask ? {2'h0, enable_mask} :
    sel_route ? {12'h000, dma_route} :
    sel_service ? {3'h0, cpu_service} :
    sel_events ? {13'h0, ctl_events} :
    sel_ev_mask ? {13'h0, ctl_ev_mask} : 16'h0000;
  wire logic [15:0] next_rdata = reg_req.rd ? rd_mux : 16'h0000;

  ////////////////////////////////////////////////////////////////////
  // Control state
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pending_flags <= 14'h0000;
      enable_mask <= 14'h0000;
      dma_route <= 4'h0;
      ctl_events <= 3'h0;
      ctl_ev_mask <= 3'h0;
      reset_pend <= 1'b0;
      nmi_pend <= 1'b0;
    end
    else
    begin
      pending_flags <= next_flags;
      enable_mask <= next_mask;
      dma_route <= wr_route ? reg_req.wdata[3:0] : dma_route;
      ctl_events <= next_events;
      ctl_ev_mask <= next_ev_mask;
      reset_pend <= next_reset_pend;
      nmi_pend <= next_nmi_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, registered from next state so they never lag an ack
  // Trap vector reads zero when not valid, so no stale slot shows
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cpu_service <= '0;
      cur_kind <= interrupt_vector_priority_pkg::SRC_NONE;
      cur_bit <= 4'h0;
      trap_valid <= 1'b0;
      trap_vector <= 7'h00;
      rdata <= 16'h0000;
      irq <= 1'b0;
    end
    else
    begin
      cpu_service <= next_service;
      cur_kind <= next_kind;
      cur_bit <= live_bit;
      trap_valid <= trap_ok;
      trap_vector <= trap_ok ? next_trap_vector : 7'h00;
      rdata <= next_rdata;
      irq <= |(next_events & next_ev_mask);
    end
  end

endmodule : interrupt_vector_priority

// ### bench/ivp_checker_sva.sv
`timescale 1ns/100ps
module ivp_checker
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requests
  input wire logic reset_pin_n,
  input wire logic nmi_request,
  input wire logic soft_trap_valid,
  input wire logic [4:0] soft_trap_num,
  // Core side
  input wire interrupt_vector_priority_pkg::service_s cpu_service,
  input wire logic trap_valid,
  input wire logic [6:0] trap_vector
);
  // One domain; nothing is judged while reset holds
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  reset_slot_a: assert property (!reset_pin_n |=> cpu_service.req &&
    cpu_service.vector == 7'h00 && cpu_service.level == 5'h01)
    else $error("reset not offered at slot zero");
  nmi_slot_a: assert property (cpu_service.req &&
    cpu_service.level == 5'h02 |-> cpu_service.vector == 7'h04)
    else $error("nonmaskable level with wrong vector");
  nmi_first_a: assert property (nmi_request && reset_pin_n |=>
    cpu_service.req && cpu_service.level <= 5'h02)
    else $error("nonmaskable request not offered first");
  mask_slot_a: assert property (cpu_service.req &&
    cpu_service.level > 5'h02 |->
    cpu_service.vector == {cpu_service.level, 2'h0} + 7'h34)
    else $error("maskable vector and level disagree");
  slot_range_a: assert property (cpu_service.req |->
    cpu_service.level inside {[5'h01:5'h10]} && cpu_service.vector < 7'h78)
    else $error("offer outside the used slots");
  soft_vector_a: assert property (soft_trap_valid &&
    soft_trap_num inside {[5'h11:5'h1E]} |=> trap_valid &&
    trap_vector == {$past(soft_trap_num) - 5'h0F, 2'h0})
    else $error("soft trap vector wrong");
  trap_nmi_a: assert property (soft_trap_valid &&
    soft_trap_num == 5'h10 |=> trap_valid && trap_vector == 7'h04)
    else $error("trap sixteen not at nonmaskable slot");
  bad_trap_a: assert property (soft_trap_valid &&
    soft_trap_num inside {5'h0E, 5'h0F, 5'h1F} |=> !trap_valid)
    else $error("unused trap number accepted");
endmodule : ivp_checker
bind interrupt_vector_priority ivp_checker ivp_checker_i
(
  .clock(clock), .rst(rst), .reset_pin_n(reset_pin_n),
  .nmi_request(nmi_request), .soft_trap_valid(soft_trap_valid),
  .soft_trap_num(soft_trap_num), .cpu_service(cpu_service),
  .trap_valid(trap_valid), .trap_vector(trap_vector)
);

// ### bench/cpu_core_model.sv
`timescale 1ns/100ps
module cpu_core_model
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Vector port
  input wire interrupt_vector_priority_pkg::service_s cpu_service,
  input wire logic [3:0] hold,
  output logic cpu_ack
);
  logic [3:0] waited;
  // Take an offer after hold cycles; a slow core lets requests pile up
  always_ff @(posedge clock)
  begin
    if (rst || cpu_ack)
    begin
      cpu_ack <= 1'b0;
      waited <= 4'h0;
    end
    else if (cpu_service.req && waited >= hold)
      cpu_ack <= 1'b1;
    else if (cpu_service.req)
      waited <= waited + 4'h1;
  end
endmodule : cpu_core_model

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clock, rst, reset_pin_n, soft_reset_trap, nmi_request, cpu_ack;
  logic soft_trap_valid, trap_valid, irq;
  logic [4:0] soft_trap_num;
  logic [13:0] src;
  logic [3:0] dma_lo, hold;
  logic [6:0] trap_vector;
  logic [15:0] rdata;
  interrupt_vector_priority_pkg::service_s cpu_service;
  interrupt_vector_priority_pkg::reg_req_s reg_req;
  logic [11:0] taken[$];
  int n_errors = 0, samples_checked = 0, cycles = 0;
  // Source bit b of src is flag position b; dma_lo feeds the shared slots
  interrupt_vector_priority interrupt_vector_priority_i
  (
    .clock(clock), .rst(rst), .reset_pin_n(reset_pin_n),
    .soft_reset_trap(soft_reset_trap), .nmi_request(nmi_request),
    .soft_trap_valid(soft_trap_valid), .soft_trap_num(soft_trap_num),
    .ext_request_0(src[0]), .ext_request_1(src[1]), .ext_request_2(src[2]),
    .timer_event(src[3]), .serial0_rx_event(src[4]),
    .serial0_tx_event(src[5]), .serial2_rx_event(src[6]),
    .serial2_tx_event(src[7]), .ext_request_3(src[8]),
    .host_port_event(src[9]), .serial1_rx_event(src[10]),
    .serial1_tx_event(src[11]), .dma_ch4_event(src[12]),
    .dma_ch5_event(src[13]), .dma_ch0_event(dma_lo[0]),
    .dma_ch1_event(dma_lo[1]), .dma_ch2_event(dma_lo[2]),
    .dma_ch3_event(dma_lo[3]), .cpu_ack(cpu_ack),
    .cpu_service(cpu_service), .trap_valid(trap_valid),
    .trap_vector(trap_vector), .reg_req(reg_req), .rdata(rdata), .irq(irq)
  );
  cpu_core_model cpu_core_model_i
  (
    .clock(clock), .rst(rst), .cpu_service(cpu_service), .hold(hold),
    .cpu_ack(cpu_ack)
  );
  ////////////////////////////////////////////////////////////////////////////
  always #25 clock = ~clock;
  // Log each vector the core takes, with its level; cut a hang short
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (!rst && cpu_ack && cpu_service.req)
      taken.push_back({cpu_service.level, cpu_service.vector});
    if (cycles == 8000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    reg_req <= '0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    reg_req <= '0;
    #1;
    check(rdata, v);
  endtask : reg_rd
  task automatic pulse(input logic [13:0] s, input logic [3:0] m,
                       input logic nmi, input logic sr);
    @(posedge clock);
    {src, dma_lo, nmi_request, soft_reset_trap} <= {s, m, nmi, sr};
    @(posedge clock);
    {src, dma_lo, nmi_request, soft_reset_trap} <= '0;
  endtask : pulse
  // Waits a bounded time for the next taken vector
  task automatic got(input logic [11:0] exp);
    for (int i = 0; i < 60 && taken.size() == 0; i++)
      @(posedge clock);
    check(taken.size() == 0 ? 16'hFFFF : {4'h0, taken.pop_front()},
          {4'h0, exp});
  endtask : got
  task automatic t_slots_routes;
    int slot[4] = '{6, 7, 10, 11};
    for (int b = 0; b < 14; b++)
    begin
      pulse(14'(1 << b), 4'h0, 1'b0, 1'b0);
      got({5'(3 + b), 7'(64 + 4 * b)});
    end
    reg_wr(8'h02, 16'h000F);
    reg_rd(8'h02, 16'h000F);
    for (int k = 0; k < 4; k++)
    begin
      pulse(14'h0000, 4'(1 << k), 1'b0, 1'b0);
      got({5'(3 + slot[k]), 7'(64 + 4 * slot[k])});
    end
    pulse(14'h0CC0, 4'h0, 1'b0, 1'b0);
    repeat (6) @(posedge clock);
    check(16'(taken.size()), 16'h0000);
    reg_wr(8'h02, 16'h0000);
    $display("slots and routes done");
  endtask : t_slots_routes
  // Slow core so reset, nonmaskable and two pins are all pending together
  task automatic t_prio;
    hold <= 4'h6;
    reset_pin_n <= 1'b0;
    pulse(14'h0003, 4'h0, 1'b1, 1'b1);
    reset_pin_n <= 1'b1;
    got({5'h01, 7'h00});
    got({5'h02, 7'h04});
    got({5'h03, 7'h40});
    got({5'h04, 7'h44});
    pulse(14'h0000, 4'h0, 1'b0, 1'b1);
    reg_rd(8'h03, 16'h1080);
    got({5'h01, 7'h00});
    pulse(14'h0001, 4'h0, 1'b1, 1'b0);
    got({5'h02, 7'h04});
    got({5'h03, 7'h40});
    hold <= 4'h0;
    $display("priority done");
  endtask : t_prio
  task automatic t_traps;
    logic [15:0] e;
    reg_rd(8'h04, 16'h0001);
    for (int n = 0; n < 32; n++)
    begin
      @(posedge clock);
      {soft_trap_valid, soft_trap_num} <= {1'b1, 5'(n)};
      @(posedge clock);
      soft_trap_valid <= 1'b0;
      #1;
      if (n == 14 || n == 15 || n == 31)
        e = 16'h0000;
      else if (n < 14)
        e = 16'(192 + 4 * (n == 6 ? 7 : n == 7 ? 6 : n));
      else
        e = 16'(128 + 4 * (n - 15));
      check({8'h00, trap_valid, trap_vector}, e);
    end
    got({5'h02, 7'h04});
    reg_rd(8'h04, 16'h0005);
    $display("traps done");
  endtask : t_traps
  // Masked flag stays pending; a second pulse meanwhile is an event
  task automatic t_mask;
    reg_wr(8'h01, 16'h0000);
    pulse(14'h000C, 4'h0, 1'b0, 1'b0);
    pulse(14'h0008, 4'h0, 1'b0, 1'b0);
    repeat (4) @(posedge clock);
    check(16'(taken.size()), 16'h0000);
    reg_rd(8'h00, 16'h000C);
    reg_wr(8'h00, 16'h0004);
    reg_rd(8'h00, 16'h0008);
    reg_wr(8'h05, 16'h0003);
    repeat (2) @(posedge clock);
    #1;
    check(16'(irq), 16'h0001);
    reg_rd(8'h04, 16'h0002);
    repeat (2) @(posedge clock);
    #1;
    check(16'(irq), 16'h0000);
    reg_wr(8'h01, 16'h3FFF);
    got({5'h06, 7'h4C});
    reg_rd(8'h00, 16'h0000);
    reg_rd(8'h05, 16'h0003);
    reg_rd(8'h3F, 16'h0000);
    $display("mask and events done");
  endtask : t_mask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    {clock, rst, reset_pin_n, hold, reg_req} = {3'b011, 4'h0, 26'h0};
    {soft_reset_trap, nmi_request, soft_trap_valid, soft_trap_num} = '0;
    {src, dma_lo} = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    check({1'b0, irq, trap_valid, cpu_service}, 16'h0000);
    reg_wr(8'h01, 16'h3FFF);
    t_slots_routes();
    t_prio();
    t_traps();
    t_mask();
    give_verdict();
  end
endmodule : tb_top
